// *** verilog/drc_pkg.sv ***
// Shared constants and types for the drive run/stop control block
package drc_pkg;
    // Data widths
    localparam int SPD_W = 16;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int SHIFT_W = 4;

    // Timing: clock period and derived cycle counts
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RAMP_TICK_NS = 1000;
    localparam int RAMP_TICK_CYC = (RAMP_TICK_NS * 1000) / CLK_PERIOD_PS;
    localparam int GATE_TIME_US = 1000;
    localparam int GATE_CYC = (GATE_TIME_US * 1000000) / CLK_PERIOD_PS;

    // Ratio is fixed point, 1.000 equals one shifted left by this
    localparam int RATIO_FRAC = 12;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_SETPOINT = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RATIO = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_JOG_SPEED = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_ACCEL = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_DECEL = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_GAIN = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_MEAS = 3'h7;

    // Reset values
    localparam logic [DATA_W-1:0] RST_SETPOINT = 16'h0000;
    localparam logic [DATA_W-1:0] RST_RATIO = 16'h1000;
    localparam logic [DATA_W-1:0] RST_JOG_SPEED = 16'h0000;
    localparam logic [DATA_W-1:0] RST_ACCEL = 16'h0001;
    localparam logic [DATA_W-1:0] RST_DECEL = 16'h0001;
    localparam logic [SHIFT_W-1:0] RST_GAIN = 4'h4;

    // Run/stop states
    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_JOG, ST_RSTOP, ST_FSTOP} drc_state_t;

    // Operator contacts, 1 means closed
    typedef struct packed {
        logic run;
        logic rstop_closed;
        logic fstop_closed;
        logic jog;
        logic closed_loop;
        logic follower;
        logic ramp_inhibit;
    } drc_contacts_t;

    // Condition flags shown to the outside
    typedef struct packed {
        logic running;
        logic ramp_stop;
        logic fast_stop;
        logic jogging;
    } drc_status_t;
endpackage

// *** verilog/drc_run_stop_ctrl.sv ***
// Run/stop latching, speed ramp, speed measurement and loop control of a DC drive
//
// What this block does
// - A closing run contact puts the drive into the running condition when both stops are closed.
// - The run condition is held internally after the run contact opens again.
// - An opened ramped stop contact ramps the speed reference down to zero at the decel rate.
// - The ramped stop is held internally until the ramp has reached zero and the ramped stop contact is closed again.
// - An opened fast stop contact forces the speed reference and drive output to zero at once.
// - The fast stop is held internally until both stop contacts are closed again.
// - Running or jogging may start only while both stop contacts are closed.
// - While the jog contact is closed the drive runs at the jog speed, except in the run condition, which takes the commanded speed.
// - Jog is not held; it ends as soon as the jog contact opens.
// - In closed loop the drive output is steered to bring reference minus feedback to zero.
// - In open loop the drive output follows the reference alone and ignores feedback.
// - In follower format the commanded speed is the reference frequency times the ratio.
// - Motor speed is the pulse count of the feedback input over a fixed gate time.
// - A fast stop zeroes the output even while ramping is inhibited.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module drc_run_stop_ctrl
    import drc_pkg::*;
#(
    parameter int GATE_CYC_P = GATE_CYC,
    parameter int RAMP_TICK_P = RAMP_TICK_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire drc_contacts_t ct_i,
    input wire logic fb_pulse_i,
    input wire logic ref_pulse_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic [SPD_W-1:0] drive_o,
    output drc_status_t status_o
);
    localparam int GW = $clog2(GATE_CYC_P + 1);
    localparam int TW = $clog2(RAMP_TICK_P + 1);
    localparam logic [SPD_W-1:0] SPD_MAX = '1;

    drc_state_t state_q;
    logic run_prev_q;
    logic fb_prev_q;
    logic ref_prev_q;
    logic [GW-1:0] gate_q;
    logic [TW-1:0] tick_cnt_q;
    logic tick_q;
    logic [SPD_W-1:0] fb_cnt_q;
    logic [SPD_W-1:0] ref_cnt_q;
    logic [SPD_W-1:0] meas_q;
    logic [SPD_W-1:0] ref_freq_q;
    logic [SPD_W-1:0] cmd_q;
    logic [SPD_W-1:0] ramp_q;
    logic [SPD_W-1:0] drive_q;
    logic [SPD_W-1:0] target_c;
    logic [DATA_W-1:0] setpoint_q;
    logic [DATA_W-1:0] ratio_q;
    logic [DATA_W-1:0] jog_spd_q;
    logic [DATA_W-1:0] accel_q;
    logic [DATA_W-1:0] decel_q;
    logic [SHIFT_W-1:0] gain_q;
    logic both_closed;
    logic run_rise;
    logic fb_rise;
    logic ref_rise;
    logic gate_end;
    logic fstop_now;
    logic [2*SPD_W-1:0] prod;
    logic signed [SPD_W:0] err;
    logic signed [SPD_W:0] step;
    logic signed [SPD_W+1:0] acc;

    // Contact edges and the stop permissive
    assign both_closed = ct_i.rstop_closed & ct_i.fstop_closed;
    assign run_rise = ct_i.run & ~run_prev_q;
    assign fb_rise = fb_pulse_i & ~fb_prev_q;
    assign ref_rise = ref_pulse_i & ~ref_prev_q;
    assign gate_end = (gate_q == GW'(GATE_CYC_P - 1));
    assign fstop_now = ~ct_i.fstop_closed | (state_q == ST_FSTOP);

    // Saturating pulse counter step
    function automatic logic [SPD_W-1:0] cnt_next(input logic [SPD_W-1:0] c, input logic e, input logic clr);
        logic [SPD_W-1:0] base;
        base = clr ? '0 : c;
        if (e && base != SPD_MAX) begin
            cnt_next = base + SPD_W'(1);
        end else begin
            cnt_next = base;
        end
    endfunction

    // Previous contact and pulse levels for edge detection
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            run_prev_q <= 1'b0;
            fb_prev_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            run_prev_q <= ct_i.run;
            fb_prev_q <= fb_pulse_i;
            ref_prev_q <= ref_pulse_i;
        end
    end

    // Run/stop state: fast stop first, then ramped stop, then start requests
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else if (!ct_i.fstop_closed) begin
            state_q <= ST_FSTOP;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (!ct_i.rstop_closed) begin
                        state_q <= ST_RSTOP;
                    end else if (run_rise) begin
                        state_q <= ST_RUN;
                    end else if (ct_i.jog) begin
                        state_q <= ST_JOG;
                    end
                end
                ST_RUN: begin
                    // Run stays latched without the contact
                    if (!ct_i.rstop_closed) begin
                        state_q <= ST_RSTOP;
                    end
                end
                ST_JOG: begin
                    if (!ct_i.rstop_closed) begin
                        state_q <= ST_RSTOP;
                    end else if (!ct_i.jog) begin
                        state_q <= ST_IDLE;
                    end else if (run_rise) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RSTOP: begin
                    // Held until the ramp is done, even if the contact recloses
                    if (ramp_q == '0 && ct_i.rstop_closed) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_FSTOP: begin
                    if (both_closed) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Ramp time base
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == TW'(RAMP_TICK_P - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + TW'(1);
            tick_q <= 1'b0;
        end
    end

    // Feedback and reference pulses counted over one gate time
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            gate_q <= '0;
            fb_cnt_q <= '0;
            ref_cnt_q <= '0;
            meas_q <= '0;
            ref_freq_q <= '0;
        end else begin
            gate_q <= gate_end ? '0 : gate_q + GW'(1);
            // Edge in the closing cycle is counted in the next window
            fb_cnt_q <= cnt_next(fb_cnt_q, fb_rise, gate_end);
            ref_cnt_q <= cnt_next(ref_cnt_q, ref_rise, gate_end);
            if (gate_end) begin
                meas_q <= fb_cnt_q;
                ref_freq_q <= ref_cnt_q;
            end
        end
    end

    // Commanded speed from setpoint or from scaled lead frequency
    assign prod = (2*SPD_W)'(ref_freq_q) * (2*SPD_W)'(ratio_q);
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cmd_q <= '0;
        end else if (!ct_i.follower) begin
            cmd_q <= setpoint_q;
        end else if (prod[2*SPD_W-1:RATIO_FRAC+SPD_W] != '0) begin
            cmd_q <= SPD_MAX; // Saturate rather than wrap on overrange
        end else begin
            cmd_q <= prod[RATIO_FRAC+:SPD_W];
        end
    end

    // Ramp target depends on the condition
    always_comb begin
        case (state_q)
            ST_RUN: target_c = cmd_q;
            ST_JOG: target_c = jog_spd_q;
            default: target_c = '0;
        endcase
    end

    // Speed ramp, frozen by the inhibit input except under fast stop
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ramp_q <= '0;
        end else if (fstop_now) begin
            ramp_q <= '0;
        end else if (tick_q && !ct_i.ramp_inhibit) begin
            if (target_c > ramp_q) begin
                ramp_q <= (target_c - ramp_q > accel_q) ? ramp_q + accel_q : target_c;
            end else if (target_c < ramp_q) begin
                ramp_q <= (ramp_q - target_c > decel_q) ? ramp_q - decel_q : target_c;
            end
        end
    end

    // Integral correction step, never zero while an error exists
    assign err = $signed({1'b0, ramp_q}) - $signed({1'b0, meas_q});
    always_comb begin
        step = err >>> gain_q;
        if (step == '0 && err != '0) begin
            step = err[SPD_W] ? -(SPD_W+1)'(1) : (SPD_W+1)'(1);
        end
    end
    assign acc = $signed({2'b00, drive_q}) + (SPD_W+2)'(step);

    // Drive output
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            drive_q <= '0;
        end else if (fstop_now) begin
            drive_q <= '0;
        end else if (!ct_i.closed_loop) begin
            drive_q <= ramp_q;
        end else if (state_q == ST_IDLE && ramp_q == '0) begin
            drive_q <= '0;
        end else if (acc < 0) begin
            drive_q <= '0;
        end else if (acc > $signed({2'b00, SPD_MAX})) begin
            drive_q <= SPD_MAX;
        end else begin
            drive_q <= acc[SPD_W-1:0];
        end
    end

    // Software writes to the configuration registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            setpoint_q <= RST_SETPOINT;
            ratio_q <= RST_RATIO;
            jog_spd_q <= RST_JOG_SPEED;
            accel_q <= RST_ACCEL;
            decel_q <= RST_DECEL;
            gain_q <= RST_GAIN;
        end else if (wr_i) begin
            case (addr_i)
                ADDR_SETPOINT: setpoint_q <= wdata_i;
                ADDR_RATIO: ratio_q <= wdata_i;
                ADDR_JOG_SPEED: jog_spd_q <= wdata_i;
                ADDR_ACCEL: accel_q <= wdata_i;
                ADDR_DECEL: decel_q <= wdata_i;
                ADDR_GAIN: gain_q <= wdata_i[SHIFT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !rd_i) begin
            rdata_o <= '0;
        end else begin
            case (addr_i)
                ADDR_SETPOINT: rdata_o <= setpoint_q;
                ADDR_RATIO: rdata_o <= ratio_q;
                ADDR_JOG_SPEED: rdata_o <= jog_spd_q;
                ADDR_ACCEL: rdata_o <= accel_q;
                ADDR_DECEL: rdata_o <= decel_q;
                ADDR_GAIN: rdata_o <= {{(DATA_W-SHIFT_W){1'b0}}, gain_q};
                ADDR_STATUS: rdata_o <= {{(DATA_W-7){1'b0}}, status_o, state_q};
                ADDR_MEAS: rdata_o <= meas_q;
                default: rdata_o <= '0;
            endcase
        end
    end

    // Output flags registered from the current state, one cycle behind it
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status_o <= '0;
        end else begin
            status_o.running <= (state_q == ST_RUN);
            status_o.ramp_stop <= (state_q == ST_RSTOP);
            status_o.fast_stop <= (state_q == ST_FSTOP);
            status_o.jogging <= (state_q == ST_JOG);
        end
    end

    assign drive_o = drive_q;

    // Checks on the control behaviour
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_run_entry: assert property (state_q == ST_IDLE && both_closed && run_rise |=> state_q == ST_RUN)
        else $error("run closure did not start the drive");
    a_run_latched: assert property (state_q == ST_RUN && both_closed |=> state_q == ST_RUN)
        else $error("run condition was not held");
    a_ramp_down: assert property (state_q == ST_RSTOP && tick_q && ct_i.fstop_closed && !ct_i.ramp_inhibit
        && ramp_q > decel_q |=> ramp_q == $past(ramp_q) - $past(decel_q))
        else $error("ramped stop did not follow the decel rate");
    a_rstop_held: assert property (state_q == ST_RSTOP && ct_i.fstop_closed && ramp_q != '0
        |=> state_q == ST_RSTOP)
        else $error("ramped stop released early");
    a_fstop_zero: assert property (!ct_i.fstop_closed |=> ramp_q == '0 && drive_o == '0
        && state_q == ST_FSTOP ##1 status_o.fast_stop)
        else $error("fast stop did not zero the output");
    a_fstop_held: assert property (state_q == ST_FSTOP && !both_closed |=> state_q == ST_FSTOP)
        else $error("fast stop released while a stop is open");
    a_no_start_open: assert property (!both_closed |=> state_q != ST_RUN && state_q != ST_JOG)
        else $error("drive running with a stop contact open");
    a_jog_target: assert property (state_q == ST_JOG |-> target_c == jog_spd_q)
        else $error("jog not aimed at jog speed");
    a_jog_ends: assert property (state_q == ST_JOG && !ct_i.jog |=> state_q != ST_JOG)
        else $error("jog continued after contact opened");
    a_closed_loop: assert property (ct_i.closed_loop && !fstop_now && state_q == ST_RUN
        && ramp_q > meas_q && drive_q != SPD_MAX |=> drive_q > $past(drive_q))
        else $error("closed loop did not act on positive error");
    a_open_loop: assert property (!ct_i.closed_loop && !fstop_now |=> drive_q == $past(ramp_q))
        else $error("open loop output differs from reference");
    a_follower: assert property (ct_i.follower && prod[2*SPD_W-1:RATIO_FRAC+SPD_W] == '0
        |=> cmd_q == $past(prod[RATIO_FRAC+:SPD_W]))
        else $error("follower speed not scaled by ratio");
    a_meas_gate: assert property (gate_end |=> meas_q == $past(fb_cnt_q)
        && fb_cnt_q == {{(SPD_W-1){1'b0}}, $past(fb_rise)})
        else $error("feedback count not taken at gate end");
    a_fresh_run: assert property (state_q == ST_IDLE && !run_rise && !ct_i.jog |=> state_q != ST_RUN)
        else $error("restart without fresh run closure");

    c_run: cover property (state_q == ST_IDLE ##1 state_q == ST_RUN);
    c_rstop_done: cover property (state_q == ST_RSTOP ##1 state_q == ST_IDLE);
    c_fstop_run: cover property (state_q == ST_RUN ##1 state_q == ST_FSTOP);
    c_jog: cover property (state_q == ST_JOG [*3] ##1 state_q == ST_IDLE);
endmodule

// *** sim/drc_pulse_src.sv ***
// Pulse train source standing in for the speed sensor and the reference frequency
`timescale 1ns/1ps
module drc_pulse_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire integer period_i,
    output logic pulse_o
);
    int cnt_q;

    // Square wave of the given period; a period of 0 means a stopped shaft, so the line idles low
    always_ff @(posedge clk_i) begin
        if (rst_i || period_i == 0) begin
            cnt_q <= 0;
            pulse_o <= 1'b0;
        end else begin
            cnt_q <= (cnt_q >= period_i - 1) ? 0 : cnt_q + 1;
            pulse_o <= (cnt_q < period_i / 2);
        end
    end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the run/stop and loop control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    import drc_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    drc_contacts_t ct = '0;
    logic fb_pulse, ref_pulse;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata, rv, d0;
    logic [SPD_W-1:0] drive;
    drc_status_t status;
    int fb_per = 10;
    int ref_per = 0;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    // Short gate and ramp tick keep the run brief
    drc_run_stop_ctrl #(.GATE_CYC_P(50), .RAMP_TICK_P(4)) dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ct_i(ct), .fb_pulse_i(fb_pulse),
        .ref_pulse_i(ref_pulse), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .drive_o(drive), .status_o(status));
    drc_pulse_src u_fb (.clk_i(core_clk_i), .rst_i(rst_i), .period_i(fb_per), .pulse_o(fb_pulse));
    drc_pulse_src u_ref (.clk_i(core_clk_i), .rst_i(rst_i), .period_i(ref_per), .pulse_o(ref_pulse));

    always #2.5 core_clk_i = ~core_clk_i;

    // Hang guard, well above the length of all tests
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc >= 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe is taken
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge core_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic pulse_run();
        @(posedge core_clk_i);
        ct.run <= 1'b1;
        @(posedge core_clk_i);
        ct.run <= 1'b0;
        tick(3);
    endtask

    task automatic open_stop(input logic fast);
        @(posedge core_clk_i);
        if (fast) ct.fstop_closed <= 1'b0;
        else ct.rstop_closed <= 1'b0;
        @(posedge core_clk_i);
        ct.fstop_closed <= 1'b1;
        ct.rstop_closed <= 1'b1;
        tick(3);
    endtask

    initial begin
        // Both stops wired closed unless a test opens one
        ct.rstop_closed = 1'b1;
        ct.fstop_closed = 1'b1;
        tick(4);
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        tick(2);
        rd_reg(ADDR_RATIO, rv);
        `CHK(rv, RST_RATIO)
        rd_reg(ADDR_DECEL, rv);
        `CHK(rv, RST_DECEL)
        rd_reg(ADDR_GAIN, rv);
        `CHK(rv, {12'h000, RST_GAIN})
        wr_reg(ADDR_STATUS, 16'hFFFF);
        rd_reg(ADDR_STATUS, rv);
        `CHK(rv, 16'h0000)
        tick(120);
        rd_reg(ADDR_MEAS, rv);
        `CHK(rv == 16'h0004 || rv == 16'h0005, 1'b1)
        $display("test registers done");

        wr_reg(ADDR_SETPOINT, 16'h0010);
        wr_reg(ADDR_ACCEL, 16'h0004);
        pulse_run();
        `CHK(status, 4'h8)
        rd_reg(ADDR_STATUS, rv);
        `CHK(rv, 16'h0041)
        tick(40);
        `CHK(drive, 16'h0010)
        open_stop(1'b0);
        `CHK(status, 4'h4)
        tick(8);
        `CHK(drive > 16'h0000 && drive < 16'h0010, 1'b1)
        tick(100);
        `CHK(drive, 16'h0000)
        `CHK(status, 4'h0)
        $display("test ramped stop done");

        // Run closure while a stop is held open is not honoured
        @(posedge core_clk_i);
        ct.rstop_closed <= 1'b0;
        tick(3);
        pulse_run();
        `CHK(status, 4'h4)
        ct.rstop_closed <= 1'b1;
        tick(5);
        `CHK(status, 4'h0)
        $display("test run refused done");

        pulse_run();
        tick(40);
        ct.ramp_inhibit <= 1'b1;
        tick(2);
        open_stop(1'b1);
        `CHK(drive, 16'h0000)
        tick(50);
        `CHK(drive, 16'h0000)
        `CHK(status[3], 1'b0)
        ct.ramp_inhibit <= 1'b0;
        $display("test fast stop done");

        wr_reg(ADDR_JOG_SPEED, 16'h0008);
        ct.jog <= 1'b1;
        tick(60);
        `CHK(drive, 16'h0008)
        `CHK(status, 4'h1)
        ct.jog <= 1'b0;
        tick(3);
        `CHK(status, 4'h0)
        tick(60);
        $display("test jog done");

        // Ratio of 2.000 on a reference giving 4 or 5 edges per gate
        wr_reg(ADDR_RATIO, 16'h2000);
        wr_reg(ADDR_DECEL, 16'h0002);
        ref_per <= 10;
        ct.follower <= 1'b1;
        tick(120);
        pulse_run();
        tick(200);
        `CHK(drive == 16'h0008 || drive == 16'h000A, 1'b1)
        open_stop(1'b1);
        ct.follower <= 1'b0;
        tick(10);
        $display("test follower done");

        // Feedback below setpoint pushes output up, above it pulls output down
        ct.closed_loop <= 1'b1;
        pulse_run();
        tick(300);
        `CHK(drive > 16'h0040, 1'b1)
        d0 = drive;
        fb_per = 2;
        // The stale count can keep steering up for up to two gate windows
        tick(250);
        `CHK(drive < d0, 1'b1)
        open_stop(1'b1);
        `CHK(drive, 16'h0000)
        $display("test closed loop done");
        complete_run();
    end
endmodule
